/* pkg/ssp_defines.svh */
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

`define SSP_WORD_W 16
`define SSP_FIFO_DEPTH 8
`define SSP_CNT_W 5
`define SSP_CTL1_MASTER_BIT 5
`define SSP_CTL1_SELEN_BIT 7
`define SSP_CTL1_SMP_BIT 9
`define SSP_STAT_OVF_BIT 6
`define SSP_STAT_EN_BIT 15
`define SSP_DIV_DEFAULT 4
`define SSP_ZERO_BIT 1'h0
`define SSP_ONE_BIT 1'h1

`endif

/* pkg/ssp_pkg.sv */
package ssp_pkg;
    typedef enum logic [1:0] {
        SSP_PINS_FOUR,
        SSP_PINS_THREE,
        SSP_PINS_TWO
    } ssp_pins_e;
    typedef enum logic [1:0] {
        SSP_FRAME_OFF,
        SSP_FRAME_MASTER_SYNC,
        SSP_FRAME_SLAVE_SYNC,
        SSP_FRAME_BOTH
    } ssp_frame_e;
endpackage : ssp_pkg

/* rtl/ssp_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module ssp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic push;
    logic pop;

    assign in_ready = level != DEPTH[$clog2(DEPTH+1)-1:0];
    assign out_valid = level != '0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            level <= level + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
        end
    end
endmodule : ssp_fifo
`default_nettype wire

/* rtl/ssp_port.sv */
// How it works
// - Standard mode moves one word at a time through the data buffer.
// - Enhanced mode queues words through an eight-deep queue each way.
// - Framed operation works as master or slave; the three framed settings act the same.
// - Pins are data in, data out, shift clock and low select/frame sync.
// - Two wire use drives no data out and no select.
// - Master select bit five picks master or slave before enabling.
// - Nothing runs until enable bit fifteen is set.
// - Master starts shifting as soon as a word is written.
// - One or two instances, each with its own registers.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.svh"
module ssp_port #(
    parameter int WORD_W = `SSP_WORD_W,
    parameter int QUEUE_DEPTH = `SSP_FIFO_DEPTH,
    parameter int DIV = `SSP_DIV_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic link_clk,
    input wire logic [15:0] serial_control_one,
    input wire ssp_pkg::ssp_pins_e pin_mode,
    input wire ssp_pkg::ssp_frame_e frame_mode,
    input wire logic enhanced_mode,
    input wire logic [15:0] serial_status_reg,
    input wire logic overflow_clear,
    input wire logic [WORD_W-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [WORD_W-1:0] serial_data_buffer,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic receive_overflow_flag,
    output logic port_irq_flag,
    output logic busy,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_out_oe,
    input wire logic shift_clock_in,
    output logic shift_clock_out,
    output logic shift_clock_oe,
    input wire logic select_sync_in_n,
    output logic select_sync_out_n,
    output logic select_sync_oe
);
    import ssp_pkg::*;

    // ****************************************
    // Configuration decode
    // ****************************************
    logic port_enable;
    logic master_select;
    logic sample_phase_select;
    logic select_pin_enable;
    logic framed;
    assign port_enable = serial_status_reg[`SSP_STAT_EN_BIT];
    assign master_select = serial_control_one[`SSP_CTL1_MASTER_BIT];
    assign sample_phase_select = serial_control_one[`SSP_CTL1_SMP_BIT];
    assign select_pin_enable = serial_control_one[`SSP_CTL1_SELEN_BIT] && pin_mode == SSP_PINS_FOUR;
    assign framed = frame_mode != SSP_FRAME_OFF;

    // ****************************************
    // Transmit queue, depth 1 or QUEUE_DEPTH
    // ****************************************
    logic [$clog2(QUEUE_DEPTH+1)-1:0] tx_level;
    logic [$clog2(QUEUE_DEPTH+1)-1:0] rx_level;
    logic txq_valid;
    logic [WORD_W-1:0] txq_data;
    logic txq_pop;
    logic txq_in_ready;
    logic depth_ok_tx;
    localparam int LVL_W = $clog2(QUEUE_DEPTH+1);
    logic [$clog2(QUEUE_DEPTH+1)-1:0] depth_lim;
    assign depth_lim = enhanced_mode ? QUEUE_DEPTH[$clog2(QUEUE_DEPTH+1)-1:0] : LVL_W'(1);
    assign depth_ok_tx = tx_level < depth_lim;
    assign tx_ready = txq_in_ready && depth_ok_tx && port_enable;

    ssp_fifo #(.WIDTH(WORD_W), .DEPTH(QUEUE_DEPTH)) u_txq (
        .clk(sys_clk),
        .arst_n(arst_n),
        .flush(!port_enable),
        .in_valid(tx_valid && depth_ok_tx && port_enable),
        .in_ready(txq_in_ready),
        .in_data(tx_data),
        .out_valid(txq_valid),
        .out_ready(txq_pop),
        .out_data(txq_data),
        .level(tx_level)
    );

    // ****************************************
    // Handshake toward the link domain
    // ****************************************
    logic req_tog;
    logic [WORD_W-1:0] req_word;
    logic ack_s1;
    logic ack_s2;
    logic ack_s3;
    logic ack_tog;
    logic [WORD_W-1:0] link_rx_word;
    logic inflight;
    logic done_pulse;
    assign done_pulse = ack_s2 != ack_s3;
    assign txq_pop = txq_valid && !inflight && port_enable;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            ack_s3 <= 1'b0;
        end else begin
            ack_s1 <= ack_tog;
            ack_s2 <= ack_s1;
            ack_s3 <= ack_s2;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            req_tog <= 1'b0;
            req_word <= '0;
            inflight <= 1'b0;
        end else if (txq_pop) begin
            req_tog <= ~req_tog;
            req_word <= txq_data;
            inflight <= 1'b1;
        end else if (done_pulse || !port_enable) begin
            // Aborted frame never returns a done
            inflight <= 1'b0;
        end
    end
    assign busy = inflight;

    // ****************************************
    // Receive queue and status flags
    // ****************************************
    logic rxq_in_ready;
    logic rxq_out_valid;
    logic [WORD_W-1:0] rxq_out_data;
    logic rx_room;
    assign rx_room = rxq_in_ready && rx_level < depth_lim;

    ssp_fifo #(.WIDTH(WORD_W), .DEPTH(QUEUE_DEPTH)) u_rxq (
        .clk(sys_clk),
        .arst_n(arst_n),
        .flush(!port_enable),
        .in_valid(done_pulse && rx_room),
        .in_ready(rxq_in_ready),
        .in_data(link_rx_word),
        .out_valid(rxq_out_valid),
        .out_ready(rx_ready),
        .out_data(rxq_out_data),
        .level(rx_level)
    );
    assign rx_valid = rxq_out_valid;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            serial_data_buffer <= '0;
        end else begin
            serial_data_buffer <= rxq_out_data;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            receive_overflow_flag <= 1'b0;
            port_irq_flag <= 1'b0;
        end else begin
            port_irq_flag <= done_pulse;
            if (done_pulse && !rx_room) begin
                receive_overflow_flag <= 1'b1;
            end else if (overflow_clear) begin
                receive_overflow_flag <= 1'b0;
            end
        end
    end

    // ****************************************
    // Link domain: master clock divider and shifter
    // ****************************************
    logic en_l1;
    logic en_l2;
    logic ms_l1;
    logic ms_l2;
    logic smp_l1;
    logic smp_l2;
    logic req_l1;
    logic req_l2;
    logic req_l3;
    logic sdi_l1;
    logic sdi_l2;
    logic sck_l1;
    logic sck_l2;
    logic sck_l3;
    logic ss_l1;
    logic ss_l2;
    logic ss_l3;
    logic [WORD_W-1:0] shreg;
    logic [`SSP_CNT_W-1:0] bitcnt;
    logic [7:0] divcnt;
    logic active;
    logic sck_int;
    logic sync_pulse;
    logic rx_bit;
    ssp_pins_e pins_l1;
    ssp_pins_e pins_l2;
    logic framed_l1;
    logic framed_l2;
    logic selen_l1;
    logic selen_l2;

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            en_l1 <= 1'b0;
            en_l2 <= 1'b0;
            ms_l1 <= 1'b0;
            ms_l2 <= 1'b0;
            smp_l1 <= 1'b0;
            smp_l2 <= 1'b0;
            req_l1 <= 1'b0;
            req_l2 <= 1'b0;
            req_l3 <= 1'b0;
            sdi_l1 <= 1'b0;
            sdi_l2 <= 1'b0;
            sck_l1 <= 1'b0;
            sck_l2 <= 1'b0;
            sck_l3 <= 1'b0;
            ss_l1 <= 1'b1;
            ss_l2 <= 1'b1;
            ss_l3 <= 1'b1;
            pins_l1 <= SSP_PINS_FOUR;
            pins_l2 <= SSP_PINS_FOUR;
            framed_l1 <= 1'b0;
            framed_l2 <= 1'b0;
            selen_l1 <= 1'b0;
            selen_l2 <= 1'b0;
        end else begin
            en_l1 <= port_enable;
            en_l2 <= en_l1;
            ms_l1 <= master_select;
            ms_l2 <= ms_l1;
            smp_l1 <= sample_phase_select;
            smp_l2 <= smp_l1;
            req_l1 <= req_tog;
            req_l2 <= req_l1;
            req_l3 <= req_l2;
            sdi_l1 <= serial_in_pin;
            sdi_l2 <= sdi_l1;
            sck_l1 <= shift_clock_in;
            sck_l2 <= sck_l1;
            sck_l3 <= sck_l2;
            ss_l1 <= select_sync_in_n;
            ss_l2 <= ss_l1;
            ss_l3 <= ss_l2;
            pins_l1 <= pin_mode;
            pins_l2 <= pins_l1;
            framed_l1 <= framed;
            framed_l2 <= framed_l1;
            selen_l1 <= select_pin_enable;
            selen_l2 <= selen_l1;
        end
    end

    logic slave_sel;
    logic slave_rise;
    logic slave_fall;
    assign slave_sel = !selen_l2 || framed_l2 || !ss_l2;
    assign slave_rise = !ms_l2 && sck_l2 && !sck_l3 && slave_sel;
    assign slave_fall = !ms_l2 && !sck_l2 && sck_l3 && slave_sel;

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            shreg <= '0;
            bitcnt <= '0;
            divcnt <= '0;
            active <= 1'b0;
            sck_int <= 1'b0;
            sync_pulse <= 1'b0;
            ack_tog <= 1'b0;
            link_rx_word <= '0;
            rx_bit <= 1'b0;
        end else if (!en_l2) begin
            active <= 1'b0;
            sck_int <= 1'b0;
            bitcnt <= '0;
            sync_pulse <= 1'b0;
        end else if (req_l2 != req_l3) begin
            shreg <= req_word;
            bitcnt <= '0;
            divcnt <= '0;
            active <= 1'b1;
            sck_int <= 1'b0;
            sync_pulse <= framed_l2;
        end else if (active && ms_l2) begin
            if (divcnt == 8'(DIV - 1)) begin
                divcnt <= '0;
                sck_int <= ~sck_int;
                sync_pulse <= 1'b0;
                if (!sck_int) begin
                    rx_bit <= sdi_l2;
                    bitcnt <= bitcnt + 1'b1;
                end else begin
                    // Shift on falling edge, clear of sampling edge
                    shreg <= {shreg[WORD_W-2:0], rx_bit};
                    if (bitcnt == `SSP_CNT_W'(WORD_W)) begin
                        active <= 1'b0;
                        link_rx_word <= {shreg[WORD_W-2:0], rx_bit};
                        ack_tog <= ~ack_tog;
                    end
                end
            end else begin
                divcnt <= divcnt + 1'b1;
            end
        end else if (active) begin
            if ((smp_l2 ? slave_fall : slave_rise)) begin
                shreg <= {shreg[WORD_W-2:0], sdi_l2};
                if (bitcnt == `SSP_CNT_W'(WORD_W - 1)) begin
                    active <= 1'b0;
                    bitcnt <= '0;
                    link_rx_word <= {shreg[WORD_W-2:0], sdi_l2};
                    ack_tog <= ~ack_tog;
                end else begin
                    bitcnt <= bitcnt + 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Pin drivers
    // ****************************************
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            serial_out_pin <= 1'b0;
            serial_out_oe <= 1'b0;
            shift_clock_out <= 1'b0;
            shift_clock_oe <= 1'b0;
            select_sync_out_n <= 1'b1;
            select_sync_oe <= 1'b0;
        end else begin
            serial_out_pin <= shreg[WORD_W-1];
            serial_out_oe <= en_l2 && pins_l2 != SSP_PINS_TWO;
            shift_clock_out <= sck_int;
            shift_clock_oe <= en_l2 && ms_l2;
            select_sync_out_n <= framed_l2 ? !sync_pulse : !active;
            select_sync_oe <= en_l2 && ms_l2 && pins_l2 == SSP_PINS_FOUR;
        end
    end
endmodule : ssp_port
`default_nettype wire

/* sim/ssp_port_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module ssp_port_props (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic link_clk,
    input wire logic [15:0] serial_control_one,
    input wire ssp_pkg::ssp_pins_e pin_mode,
    input wire logic [15:0] serial_status_reg,
    input wire logic overflow_clear,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic receive_overflow_flag,
    input wire logic port_irq_flag,
    input wire logic busy,
    input wire logic serial_out_oe,
    input wire logic shift_clock_oe,
    input wire logic select_sync_oe
);
    import ssp_pkg::*;
    // ****
    // Core domain
    // ****
    AST_OFF_REFUSES: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !serial_status_reg[15] |-> !tx_ready) else $error("word accepted while off");
    AST_ACCEPT_BUSY: assert property (@(posedge sys_clk) disable iff (!arst_n)
        tx_valid && tx_ready && !busy |-> ##[1:2] busy) else $error("no start after write");
    AST_IRQ_PULSE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        port_irq_flag |=> !port_irq_flag) else $error("done flag longer than a cycle");
    AST_IRQ_DATA: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(port_irq_flag) |-> ##[0:3] rx_valid) else $error("done without word");
    AST_OVF_STICKY: assert property (@(posedge sys_clk) disable iff (!arst_n)
        receive_overflow_flag && !overflow_clear && serial_status_reg[15] |=> receive_overflow_flag)
        else $error("overflow dropped by itself");
    // ****
    // Link domain
    // ****
    AST_TWO_WIRE: assert property (@(posedge link_clk) disable iff (!arst_n)
        (pin_mode == SSP_PINS_TWO) [*6] |=> !serial_out_oe && !select_sync_oe)
        else $error("two wire drives data out or select");
    AST_THREE_WIRE: assert property (@(posedge link_clk) disable iff (!arst_n)
        (pin_mode == SSP_PINS_THREE) [*6] |=> !select_sync_oe) else $error("three wire drives select");
    AST_SLAVE_NO_SCK: assert property (@(posedge link_clk) disable iff (!arst_n)
        (!serial_control_one[5]) [*6] |=> !shift_clock_oe) else $error("slave drives clock");
    AST_MASTER_SCK: assert property (@(posedge link_clk) disable iff (!arst_n)
        (serial_control_one[5] && serial_status_reg[15]) [*6] |=> shift_clock_oe)
        else $error("master not driving clock");
    COV_DONE: cover property (@(posedge sys_clk) disable iff (!arst_n) port_irq_flag);
    COV_OVF: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(receive_overflow_flag));
    COV_FULL: cover property (@(posedge sys_clk) disable iff (!arst_n)
        tx_valid && !tx_ready && serial_status_reg[15]);
endmodule : ssp_port_props
`default_nettype wire

/* sim/ssp_far_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module ssp_far_slave (
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    output logic [15:0] got
);
    logic [15:0] resp = 16'h9C31;
    logic [15:0] sh = 16'h0000;
    logic [4:0] n = 5'h00;
    initial begin
        miso = 1'b0;
        got = 16'h0000;
    end
    // Capture on rising clock, MSB first
    always @(posedge sck) begin
        if (!cs_n) begin
            sh = {sh[14:0], mosi};
            n = n + 5'h01;
            if (n == 5'h10) begin
                got = sh;
                resp = resp + 16'h0111;
                n = 5'h00;
            end
        end
    end
    always @(negedge sck) begin
        if (!cs_n) miso = resp[4'hF - n[3:0]];
    end
    always @(negedge cs_n) begin
        n = 5'h00;
        miso = resp[15];
    end
    // Released line shows stale inverse
    always @(posedge cs_n) begin
        miso = ~miso;
    end
endmodule : ssp_far_slave
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ssp_pkg::*;
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] serial_control_one = 16'h0020;
    ssp_pins_e pin_mode = SSP_PINS_FOUR;
    ssp_frame_e frame_mode = SSP_FRAME_OFF;
    logic enhanced_mode = 1'b0;
    logic [15:0] serial_status_reg = 16'h0000;
    logic overflow_clear = 1'b0;
    logic [15:0] tx_data = 16'h0000;
    logic tx_valid = 1'b0;
    logic rx_ready = 1'b0;
    logic tx_ready, rx_valid, ovf, irq, busy, sdo, sdo_oe, sck, sck_oe, ss_n, ss_oe, sdi;
    logic [15:0] serial_data_buffer, got;
    logic [15:0] k = 16'h0000;
    logic [15:0] rq = 16'h0000;
    int err_total = 0;
    int n_compared = 0;
    wire logic ss_line = ss_oe ? ss_n : 1'b1;
    wire logic sck_line = sck_oe ? sck : 1'b0;
    always #2.5 sys_clk = ~sys_clk;
    initial begin
        #1.3;
        forever #7.5 link_clk = ~link_clk;
    end
    ssp_port dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .link_clk(link_clk),
        .serial_control_one(serial_control_one), .pin_mode(pin_mode), .frame_mode(frame_mode),
        .enhanced_mode(enhanced_mode), .serial_status_reg(serial_status_reg),
        .overflow_clear(overflow_clear), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .serial_data_buffer(serial_data_buffer), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .receive_overflow_flag(ovf), .port_irq_flag(irq), .busy(busy), .serial_in_pin(sdi),
        .serial_out_pin(sdo), .serial_out_oe(sdo_oe), .shift_clock_in(1'b0),
        .shift_clock_out(sck), .shift_clock_oe(sck_oe), .select_sync_in_n(1'b1),
        .select_sync_out_n(ss_n), .select_sync_oe(ss_oe));
    ssp_far_slave far_u (.sck(sck_line), .cs_n(ss_line), .mosi(sdo), .miso(sdi), .got(got));
    task automatic print_verdict;
        if (err_total == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic cmp16(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : cmp16
    task automatic cmp1(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %b got %b", nm, e, g);
        end
    endtask : cmp1
    task automatic push(input logic [15:0] d, input int lim, output bit ok);
        tx_data = d;
        tx_valid = 1'b1;
        ok = 0;
        for (int i = 0; i < lim && !ok; i++) begin
            #1;
            ok = (tx_ready === 1'b1);
            @(negedge sys_clk);
        end
    endtask : push
    task automatic wait_irq;
        bit f;
        f = 0;
        for (int i = 0; i < 4000 && !f; i++) begin
            @(negedge sys_clk);
            f = (irq === 1'b1);
        end
        if (!f) begin
            cmp1("irq wait", 1'b1, 1'b0);
            print_verdict();
        end
    endtask : wait_irq
    task automatic pop_cmp;
        bit f;
        f = 0;
        for (int i = 0; i < 50 && !f; i++) begin
            @(negedge sys_clk);
            f = (rx_valid === 1'b1);
        end
        if (!f) begin
            cmp1("rx wait", 1'b1, 1'b0);
            print_verdict();
        end
        @(negedge sys_clk);
        cmp16("rx word", 16'h9C31 + 16'h0111 * rq, serial_data_buffer);
        rq++;
        rx_ready = 1'b1;
        @(negedge sys_clk);
        rx_ready = 1'b0;
    endtask : pop_cmp
    task automatic send(input logic [15:0] d);
        bit ok;
        push(d, 50, ok);
        tx_valid = 1'b0;
        cmp1("tx accept", 1'b1, ok);
        wait_irq();
        cmp16("far word", d, got);
        k++;
    endtask : send
    task automatic set_en(input logic [15:0] s);
        serial_status_reg = s;
        repeat (20) @(negedge sys_clk);
    endtask : set_en
    initial begin
        bit ok;
        int n;
        repeat (2) @(negedge link_clk);
        @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        cmp1("irq idle", 1'b0, irq);
        push(16'hA55A, 4, ok);
        tx_valid = 1'b0;
        cmp1("accept off", 1'b0, ok);
        overflow_clear = 1'b1;
        @(negedge sys_clk);
        overflow_clear = 1'b0;
        set_en(16'h8000);
        cmp1("master sck oe", 1'b1, sck_oe);
        send(16'hA55A);
        pop_cmp();
        send(16'h0F0F);
        send(16'hF0F0);
        cmp1("overflow", 1'b1, ovf);
        set_en(16'h0000);
        rq = k;
        overflow_clear = 1'b1;
        @(negedge sys_clk);
        overflow_clear = 1'b0;
        @(negedge sys_clk);
        cmp1("overflow clear", 1'b0, ovf);
        enhanced_mode = 1'b1;
        set_en(16'h8000);
        n = 0;
        ok = 1;
        while (ok && n < 12) begin
            push(16'h1000 + 16'(n), 3, ok);
            if (ok) n++;
        end
        tx_valid = 1'b0;
        cmp1("queue depth", 1'b1, n == 8 || n == 9);
        for (int i = 0; i < n; i++) begin
            wait_irq();
            cmp16("far queued", 16'h1000 + 16'(i), got);
            k++;
            pop_cmp();
        end
        set_en(16'h0000);
        enhanced_mode = 1'b0;
        frame_mode = SSP_FRAME_MASTER_SYNC;
        set_en(16'h8000);
        push(16'h3C3C, 50, ok);
        tx_valid = 1'b0;
        n = 0;
        for (int i = 0; i < 4000 && irq !== 1'b1; i++) begin
            @(negedge sys_clk);
            if (ss_line === 1'b0) n++;
        end
        cmp1("framed done", 1'b1, irq);
        cmp1("frame sync short", 1'b1, n > 0 && n < 40);
        set_en(16'h0000);
        cmp1("buffer cleared", 1'b0, rx_valid);
        frame_mode = SSP_FRAME_OFF;
        pin_mode = SSP_PINS_THREE;
        set_en(16'h8000);
        cmp1("three wire sel oe", 1'b0, ss_oe);
        set_en(16'h0000);
        pin_mode = SSP_PINS_TWO;
        set_en(16'h8000);
        cmp1("two wire sdo oe", 1'b0, sdo_oe);
        cmp1("two wire sel oe", 1'b0, ss_oe);
        set_en(16'h0000);
        pin_mode = SSP_PINS_FOUR;
        serial_control_one = 16'h0080;
        set_en(16'h8000);
        cmp1("slave sck oe", 1'b0, sck_oe);
        print_verdict();
    end
endmodule : tb_top
bind ssp_port ssp_port_props chk_u (.sys_clk(sys_clk), .arst_n(arst_n), .link_clk(link_clk),
    .serial_control_one(serial_control_one), .pin_mode(pin_mode), .serial_status_reg(serial_status_reg),
    .overflow_clear(overflow_clear), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .receive_overflow_flag(receive_overflow_flag), .port_irq_flag(port_irq_flag), .busy(busy),
    .serial_out_oe(serial_out_oe), .shift_clock_oe(shift_clock_oe), .select_sync_oe(select_sync_oe));
`default_nettype wire
